// >>> design/rhp_consts.svh
// Offsets, field positions, reset values and timing values (microseconds, clock MHz) of the root hub port block
`ifndef RHP_CONSTS_SVH
`define RHP_CONSTS_SVH

// Register byte addresses
`define RHP_PORT_STATUS_ADDR 12'h000
`define RHP_CTRL_ADDR        12'h004
`define RHP_IRQ_STATUS_ADDR  12'h008
`define RHP_IRQ_MASK_ADDR    12'h00c

// Port status word bits
`define RHP_CONNECT_BIT      0
`define RHP_ENABLE_BIT       1
`define RHP_SUSPEND_BIT      2
`define RHP_RESUME_BIT       3
`define RHP_RESET_BIT        4
`define RHP_POWER_ON_BIT     8
`define RHP_POWER_OFF_BIT    9
`define RHP_CONN_CHG_BIT     16
`define RHP_EN_CHG_BIT       17
`define RHP_SUSP_CHG_BIT     18
`define RHP_RST_CHG_BIT      20

// Control register bits
`define RHP_CTRL_NONREM_BIT  0

// Interrupt status bits
`define RHP_IRQ_CONN_BIT     0
`define RHP_IRQ_EN_BIT       1
`define RHP_IRQ_SUSP_BIT     2
`define RHP_IRQ_RST_BIT      3

// Reset values
`define RHP_CTRL_RESET       1'h0
`define RHP_IRQ_MASK_RESET   4'h0

// Timing
`define RHP_DEBOUNCE_US      100
`define RHP_PORT_RESET_US    10000
`define RHP_RESUME_US        20000
`define RHP_CLK_MHZ          50

`endif

// >>> design/rhp_pkg.sv
// Types of the root hub port block
package rhp_pkg;

  typedef enum logic [3:0] {
    RHP_ST_IDLE    = 4'b0001,
    RHP_ST_RESET   = 4'b0010,
    RHP_ST_SUSPEND = 4'b0100,
    RHP_ST_RESUME  = 4'b1000
  } rhp_seq_t;

endpackage

// >>> design/rhp_debounce.sv
// Attach detector: three-flop synchroniser plus debounce timer
`timescale 1ns/100ps
`include "rhp_consts.svh"
module rhp_debounce #(
  parameter int CYCLES = `RHP_DEBOUNCE_US * `RHP_CLK_MHZ
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Line state
  input  wire logic attach_raw,
  // Debounced level
  output logic      attached
);

  typedef struct packed {
    logic [2:0]  sync;
    logic [31:0] cnt;
    logic        level;
  } rhp_db_t;

  rhp_db_t st;
  rhp_db_t next_st;

  always_comb begin
    next_st      = st;
    next_st.sync = {st.sync[1:0], attach_raw};
    // Only flops two and three are compared; flop one feeds flop two alone
    if (st.sync[1] != st.sync[2]) begin
      next_st.cnt = 32'h0;
    end else if (st.sync[2] == st.level) begin
      next_st.cnt = 32'h0;
    end else if (st.cnt >= 32'(CYCLES - 1)) begin
      next_st.level = st.sync[2];
      next_st.cnt   = 32'h0;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign attached = st.level;

endmodule

// >>> design/rhp_port.sv
// Root hub downstream port: enable and connect status, APB registers, interrupt
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "rhp_consts.svh"
module rhp_port
  import rhp_pkg::*;
#(
  parameter int RESET_CYCLES  = `RHP_PORT_RESET_US * `RHP_CLK_MHZ,
  parameter int RESUME_CYCLES = `RHP_RESUME_US * `RHP_CLK_MHZ,
  parameter int DEBOUNCE_CYC  = `RHP_DEBOUNCE_US * `RHP_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Port line and fault inputs
  input  wire logic        line_attach,
  input  wire logic        overcurrent,
  input  wire logic        bus_error,
  // Port drive
  output logic             port_reset_drive,
  output logic             port_suspended,
  output logic             port_powered,
  // Interrupt
  output logic             irq
);

  import rhp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [2:0]  oc_sync;
    logic [2:0]  err_sync;
    logic        attached_q;
    logic        connect;
    logic        enable;
    logic        suspend;
    logic        reset;
    logic        powered;
    logic        conn_chg;
    logic        en_chg;
    logic        susp_chg;
    logic        rst_chg;
    rhp_seq_t    seq;
    logic [31:0] timer;
    logic        nonrem;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        irq;
  } rhp_state_t;

  rhp_state_t st;
  rhp_state_t next_st;
  logic       attached;

  // Address decode used only for pslverr; read and write paths compare paddr themselves
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `RHP_PORT_STATUS_ADDR) || (a == `RHP_CTRL_ADDR) ||
             (a == `RHP_IRQ_STATUS_ADDR) || (a == `RHP_IRQ_MASK_ADDR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  rhp_debounce #(
    .CYCLES (DEBOUNCE_CYC)
  ) u_debounce (
    .pclk       (pclk),
    .presetn    (presetn),
    .attach_raw (line_attach),
    .attached   (attached)
  );

  ////////////////////////////////////////////////////////////////////////////

  logic        acc;
  logic        wr;
  logic        rd;
  logic        conn_now;
  logic        oc_lvl;
  logic        err_lvl;
  logic [31:0] status_word;

  always_comb begin
    next_st = st;
    acc     = psel && penable && !st.ready;
    wr      = acc && pwrite && (paddr == `RHP_PORT_STATUS_ADDR);
    rd      = acc && !pwrite;

    // Fault pins pass three flops; act once flops two and three are both high
    next_st.oc_sync  = {st.oc_sync[1:0], overcurrent};
    next_st.err_sync = {st.err_sync[1:0], bus_error};
    oc_lvl  = st.oc_sync[1] && st.oc_sync[2];
    err_lvl = st.err_sync[1] && st.err_sync[2];

    conn_now = attached || st.nonrem;
    next_st.attached_q = conn_now;
    next_st.connect = conn_now;
    // change flag on attach or detach
    if (conn_now != st.attached_q) begin
      next_st.conn_chg = 1'b1;
    end

    // Change flags are write-one-to-clear; a same-cycle set below wins
    if (wr) begin
      if (pwdata[`RHP_CONN_CHG_BIT]) next_st.conn_chg = 1'b0;
      if (pwdata[`RHP_EN_CHG_BIT])   next_st.en_chg   = 1'b0;
      if (pwdata[`RHP_SUSP_CHG_BIT]) next_st.susp_chg = 1'b0;
      if (pwdata[`RHP_RST_CHG_BIT])  next_st.rst_chg  = 1'b0;
      if (pwdata[`RHP_POWER_ON_BIT]) next_st.powered  = 1'b1;
      if (pwdata[`RHP_POWER_OFF_BIT]) next_st.powered = 1'b0;
      if (conn_now != st.attached_q) next_st.conn_chg = 1'b1;
    end

    // write one to bit 0 clears enable
    if (wr && pwdata[`RHP_CONNECT_BIT]) begin
      next_st.enable = 1'b0;
    end
    // write one to bit 1 sets enable if connected, else sets the connect change flag
    if (wr && pwdata[`RHP_ENABLE_BIT]) begin
      if (st.connect) begin
        next_st.enable = 1'b1;
      end else begin
        next_st.conn_chg = 1'b1;
      end
    end

    // Suspend and resume requests, refused while disconnected
    if (wr && pwdata[`RHP_SUSPEND_BIT] && st.seq == RHP_ST_IDLE) begin
      if (st.connect) begin
        next_st.suspend = 1'b1;
        next_st.seq     = RHP_ST_SUSPEND;
      end else begin
        next_st.conn_chg = 1'b1;
      end
    end
    if (wr && pwdata[`RHP_RESUME_BIT] && st.seq == RHP_ST_SUSPEND) begin
      next_st.seq   = RHP_ST_RESUME;
      next_st.timer = 32'h0;
    end

    // set port reset starts reset signalling if connected, else sets the connect change flag
    if (wr && pwdata[`RHP_RESET_BIT] && st.seq != RHP_ST_RESET) begin
      if (st.connect) begin
        next_st.reset = 1'b1;
        next_st.seq   = RHP_ST_RESET;
        next_st.timer = 32'h0;
      end else begin
        next_st.conn_chg = 1'b1;
      end
    end

    case (st.seq)
      RHP_ST_IDLE: begin
      end
      RHP_ST_SUSPEND: begin
      end
      RHP_ST_RESET: begin
        next_st.timer = st.timer + 32'h1;
        if (st.timer >= 32'(RESET_CYCLES - 1)) begin
          next_st.reset   = 1'b0;
          next_st.rst_chg = 1'b1;
          next_st.suspend = 1'b0;
          next_st.seq     = RHP_ST_IDLE;
          next_st.enable  = conn_now;
        end
      end
      RHP_ST_RESUME: begin
        next_st.timer = st.timer + 32'h1;
        if (st.timer >= 32'(RESUME_CYCLES - 1)) begin
          next_st.suspend  = 1'b0;
          next_st.susp_chg = 1'b1;
          next_st.seq      = RHP_ST_IDLE;
          next_st.enable   = conn_now;
        end
      end
      default: begin
        next_st.seq = RHP_ST_IDLE;
      end
    endcase

    // hardware disables on fault, detach or power loss
    if (st.enable && (oc_lvl || err_lvl || !conn_now || !st.powered)) begin
      next_st.enable = 1'b0;
      next_st.en_chg = 1'b1;
    end
    if (!conn_now) begin
      next_st.enable = 1'b0;
      next_st.reset  = 1'b0;
      next_st.suspend = 1'b0;
      next_st.seq    = RHP_ST_IDLE;
    end

    // Control and mask registers
    if (acc && pwrite && paddr == `RHP_CTRL_ADDR) begin
      next_st.nonrem = pwdata[`RHP_CTRL_NONREM_BIT];
    end
    if (acc && pwrite && paddr == `RHP_IRQ_MASK_ADDR) begin
      next_st.irq_mask = pwdata[3:0];
    end

    // Sticky interrupt status; read clears, new event wins
    if (rd && paddr == `RHP_IRQ_STATUS_ADDR) begin
      next_st.irq_stat = 4'h0;
    end
    next_st.irq_stat[`RHP_IRQ_CONN_BIT] = next_st.irq_stat[`RHP_IRQ_CONN_BIT] |
                                          (next_st.conn_chg & ~st.conn_chg);
    next_st.irq_stat[`RHP_IRQ_EN_BIT]   = next_st.irq_stat[`RHP_IRQ_EN_BIT] |
                                          (next_st.en_chg & ~st.en_chg);
    next_st.irq_stat[`RHP_IRQ_SUSP_BIT] = next_st.irq_stat[`RHP_IRQ_SUSP_BIT] |
                                          (next_st.susp_chg & ~st.susp_chg);
    next_st.irq_stat[`RHP_IRQ_RST_BIT]  = next_st.irq_stat[`RHP_IRQ_RST_BIT] |
                                          (next_st.rst_chg & ~st.rst_chg);
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

    status_word = 32'h0;
    status_word[`RHP_CONNECT_BIT]  = st.connect;
    status_word[`RHP_ENABLE_BIT]   = st.enable;
    status_word[`RHP_SUSPEND_BIT]  = st.suspend;
    status_word[`RHP_RESET_BIT]    = st.reset;
    status_word[`RHP_POWER_ON_BIT] = st.powered;
    status_word[`RHP_CONN_CHG_BIT] = st.conn_chg;
    status_word[`RHP_EN_CHG_BIT]   = st.en_chg;
    status_word[`RHP_SUSP_CHG_BIT] = st.susp_chg;
    status_word[`RHP_RST_CHG_BIT]  = st.rst_chg;

    // One wait state: answer on the cycle after the access phase opens
    next_st.ready  = acc;
    next_st.slverr = acc && !mapped(paddr);
    next_st.rdata  = 32'h0;
    if (rd) begin
      case (paddr)
        `RHP_PORT_STATUS_ADDR: next_st.rdata = status_word;
        `RHP_CTRL_ADDR:        next_st.rdata = {31'h0, st.nonrem};
        `RHP_IRQ_STATUS_ADDR:  next_st.rdata = {28'h0, st.irq_stat};
        `RHP_IRQ_MASK_ADDR:    next_st.rdata = {28'h0, st.irq_mask};
        default:               next_st.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.seq      <= RHP_ST_IDLE;
      st.powered  <= 1'b1;
      st.nonrem   <= `RHP_CTRL_RESET;
      st.irq_mask <= `RHP_IRQ_MASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign prdata           = st.rdata;
  assign pready           = st.ready;
  assign pslverr          = st.slverr;
  assign port_reset_drive = st.reset;
  assign port_suspended   = st.suspend;
  assign port_powered     = st.powered;
  assign irq              = st.irq;

endmodule

// >>> test/rhp_port_checker.sv
// Assertion checker for the root hub port block
`timescale 1ns/100ps
`include "rhp_consts.svh"
module rhp_port_checker #(
  parameter int DEBOUNCE_CYC = 4
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Port and interrupt
  input wire logic        line_attach,
  input wire logic        overcurrent,
  input wire logic        bus_error,
  input wire logic        port_reset_drive,
  input wire logic        port_suspended,
  input wire logic        port_powered,
  input wire logic        irq
);
  logic        take;
  logic        rd_stat_q;
  logic        bad_q;
  logic [15:0] att_cnt;
  assign take = psel && penable && !pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_stat_q <= 1'b0;
      bad_q     <= 1'b0;
      att_cnt   <= 16'h0;
    end else begin
      if (take) begin
        rd_stat_q <= !pwrite && paddr == `RHP_PORT_STATUS_ADDR;
        bad_q     <= paddr > `RHP_IRQ_MASK_ADDR;
      end
      // Saturates so a long attach never wraps back
      att_cnt <= !line_attach ? 16'h0 : att_cnt + {15'h0, att_cnt != 16'hffff};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take; take; endsequence
  sequence s_mask_off;
    take && pwrite && paddr == `RHP_IRQ_MASK_ADDR && pwdata[3:0] == 4'h0;
  endsequence
  property p_rdy_lat; s_take |=> pready; endproperty
  property p_rdy_pulse; pready |=> !pready; endproperty
  property p_idle_out; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  property p_slverr; pready |-> pslverr == bad_q; endproperty
  property p_en_conn; pready && rd_stat_q && !prdata[0] |-> !prdata[1]; endproperty
  property p_conn_live;
    pready && rd_stat_q && att_cnt > DEBOUNCE_CYC + 8 |-> prdata[0];
  endproperty
  property p_rst_hold; $rose(port_reset_drive) |-> port_reset_drive [*8]; endproperty
  property p_mask_off; s_mask_off |-> ##2 !irq; endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("pready late");
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  a_idle_out: assert property (p_idle_out) else $error("output outside answer");
  a_slverr: assert property (p_slverr) else $error("pslverr wrong");
  a_en_conn: assert property (p_en_conn) else $error("enabled while detached");
  a_conn_live: assert property (p_conn_live) else $error("attach not shown");
  a_rst_hold: assert property (p_rst_hold) else $error("reset drive short");
  a_mask_off: assert property (p_mask_off) else $error("masked irq high");
endmodule
bind rhp_port rhp_port_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .line_attach(line_attach), .overcurrent(overcurrent), .bus_error(bus_error),
  .port_reset_drive(port_reset_drive), .port_suspended(port_suspended),
  .port_powered(port_powered), .irq(irq));

// >>> test/rhp_usb_dev.sv
// Behavioural USB device on the downstream port
`timescale 1ns/100ps
module rhp_usb_dev (
  // Bench controls
  input  wire logic plugged,
  input  wire logic short_req,
  input  wire logic err_req,
  // Port side
  input  wire logic port_powered,
  output logic      line_attach,
  output logic      overcurrent,
  output logic      bus_error
);
  // An unpowered device cannot pull the line, so power off looks like detach
  assign line_attach = plugged && port_powered;
  assign overcurrent = short_req && port_powered;
  assign bus_error   = err_req && plugged;
endmodule

// >>> test/root_hub_port_enable_connect_tb_top.sv
// Self-checking testbench of the root hub port block
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("Error t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module root_hub_port_enable_connect_tb_top;
  localparam int          DEB = 4;
  localparam int          RST = 20;
  localparam logic [11:0] ST  = 12'h000;
  localparam logic [11:0] CT  = 12'h004;
  localparam logic [11:0] IS  = 12'h008;
  localparam logic [11:0] IM  = 12'h00c;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        line_attach, overcurrent, bus_error, plugged, short_req, err_req;
  logic        port_reset_drive, port_suspended, port_powered;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_fail, cmp_count, cyc;
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  rhp_port #(.RESET_CYCLES(RST), .RESUME_CYCLES(RST), .DEBOUNCE_CYC(DEB)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_attach(line_attach), .overcurrent(overcurrent), .bus_error(bus_error),
    .port_reset_drive(port_reset_drive), .port_suspended(port_suspended),
    .port_powered(port_powered), .irq(irq));
  rhp_usb_dev u_dev (.plugged(plugged), .short_req(short_req), .err_req(err_req),
    .port_powered(port_powered), .line_attach(line_attach), .overcurrent(overcurrent),
    .bus_error(bus_error));
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Setup cycle, access until pready, release, one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look at the answer mid-cycle, where it has settled; the edge after it ends the access
    do @(negedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdm(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic t_reset_values();
    rdm(ST);
    `CHK(rd, 32'h0000_0100)
    rdm(CT);
    `CHK(rd, 32'h0)
    rdm(IM);
    `CHK(rd, 32'h0)
    $display("reset values done");
  endtask
  task automatic t_disc_enable();
    wr(IM, 32'h1);
    wr(ST, 32'h2);
    tick(2);
    `CHK(irq, 1'b1)
    rdm(ST);
    `CHK(rd, 32'h0001_0100)
    rdm(IS);
    `CHK(rd, 32'h1)
    `CHK(irq, 1'b0)
    wr(ST, 32'h1_0000);
    wr(IM, 32'h0);
    wr(ST, 32'h4);
    tick(2);
    `CHK(irq, 1'b0)
    wr(IM, 32'h1);
    tick(2);
    `CHK(irq, 1'b1)
    rdm(IS);
    wr(ST, 32'h1_0000);
    wr(IM, 32'h0);
    $display("disconnected enable done");
  endtask
  task automatic t_connect();
    plugged <= 1'b1;
    tick(DEB + 12);
    rdm(ST);
    `CHK(rd, 32'h0001_0101)
    wr(ST, 32'h1_0000);
    wr(ST, 32'h0);
    rdm(ST);
    `CHK(rd, 32'h0000_0101)
    wr(ST, 32'h2);
    rdm(ST);
    `CHK(rd, 32'h0000_0103)
    wr(ST, 32'h1);
    rdm(ST);
    `CHK(rd, 32'h0000_0101)
    $display("connect and enable done");
  endtask
  task automatic t_reset_resume();
    wr(ST, 32'h10);
    `CHK(port_reset_drive, 1'b1)
    rdm(ST);
    `CHK(rd, 32'h0000_0111)
    tick(RST + 4);
    rdm(ST);
    `CHK(rd, 32'h0010_0103)
    wr(ST, 32'h10_0001);
    wr(ST, 32'h4);
    `CHK(port_suspended, 1'b1)
    wr(ST, 32'h8);
    tick(RST + 4);
    rdm(ST);
    `CHK(rd, 32'h0004_0103)
    wr(ST, 32'h4_0000);
    $display("reset and resume done");
  endtask
  task automatic t_faults();
    for (int k = 0; k < 3; k++) begin
      wr(ST, 32'h2);
      if (k == 0) short_req <= 1'b1;
      else if (k == 1) err_req <= 1'b1;
      else begin
        wr(ST, 32'h200);
        `CHK(port_powered, 1'b0)
      end
      tick(6);
      rdm(ST);
      `CHK(rd & 32'h0002_0002, 32'h0002_0000)
      short_req <= 1'b0;
      err_req <= 1'b0;
      wr(ST, 32'h100);
      tick(DEB + 12);
      wr(ST, 32'h3_0000);
    end
    wr(ST, 32'h2);
    plugged <= 1'b0;
    tick(DEB + 12);
    rdm(ST);
    `CHK(rd & 32'h3_0003, 32'h3_0000)
    wr(ST, 32'h3_0000);
    $display("faults done");
  endtask
  task automatic t_nonrem_unmapped();
    wr(CT, 32'h1);
    rdm(ST);
    `CHK(rd[0], 1'b1)
    wr(CT, 32'h0);
    tick(DEB + 12);
    rdm(ST);
    `CHK(rd[0], 1'b0)
    wr(12'h010, 32'hffff_ffff);
    `CHK(err, 1'b1)
    rdm(12'h010);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("nonremovable and unmapped done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // A hung handshake ends here as a mismatch
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {plugged, short_req, err_req, n_fail, cmp_count, cyc} = '0;
    tick(8);
    presetn <= 1'b1;
    tick(1);
    t_reset_values();
    t_disc_enable();
    t_connect();
    t_reset_resume();
    t_faults();
    t_nonrem_unmapped();
    end_of_test();
  end
endmodule
